//--- src/chan_diag.sv
`timescale 1ns/10ps
`include "fault_map.svh"
module chan_diag (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        diag_en,
    input  wire logic                        restart_all,
    input  wire logic                        cmd_on,
    input  wire logic                        above_ol,
    input  wire logic                        below_sg,
    input  wire logic                        above_short,
    output logic                             sample_p,
    output fault_types_pkg::fault_code_t     sample_code,
    output fault_types_pkg::fault_code_t     det_code
);
    import fault_types_pkg::*;

    localparam logic [`CNT_W-1:0] CYC_ON  = `CNT_W'(`CYC_BL_ON);
    localparam logic [`CNT_W-1:0] CYC_OFF = `CNT_W'(`CYC_BL_OFF);
    localparam logic [`CNT_W-1:0] CYC_FF  = `CNT_W'(`CYC_FILT);

    fault_code_t       raw;
    fault_code_t       raw_d_r;
    logic              cmd_d_r;
    timer_state_t      state_r;
    logic [`CNT_W-1:0] cnt_r;
    logic              expire;

    // Reference choice follows the commanded state
    always_comb begin
        if (cmd_on) begin
            raw = above_short ? `CODE_SHORT : `CODE_NONE;
        end else if (above_ol) begin
            raw = `CODE_NONE;
        end else if (below_sg) begin
            raw = `CODE_GND;
        end else begin
            raw = `CODE_OPEN;
        end
    end

    assign expire = (state_r != TMR_IDLE) && (cnt_r == `CNT_W'(1));

    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_d_r <= 1'b0;
            raw_d_r <= `CODE_NONE;
        end else begin
            cmd_d_r <= cmd_on;
            raw_d_r <= raw;
        end
    end

    // ****************************************************
    // Blanking and filter timer
    // ****************************************************
    always_ff @(posedge clk) begin
        if (srst || !diag_en) begin
            state_r <= TMR_IDLE;
            cnt_r   <= '0;
        end else if (restart_all || cmd_on != cmd_d_r) begin
            state_r <= TMR_BLANK;
            cnt_r   <= cmd_on ? CYC_ON : CYC_OFF;
        end else begin
            case (state_r)
                TMR_IDLE: begin
                    if (raw != raw_d_r) begin
                        state_r <= TMR_FILTER;
                        cnt_r   <= CYC_FF;
                    end
                end
                TMR_FILTER: begin
                    if (raw != raw_d_r) begin
                        cnt_r <= CYC_FF;
                    end else if (expire) begin
                        state_r <= TMR_IDLE;
                    end else begin
                        cnt_r <= cnt_r - `CNT_W'(1);
                    end
                end
                TMR_BLANK: begin
                    if (expire) begin
                        state_r <= TMR_IDLE;
                    end else begin
                        cnt_r <= cnt_r - `CNT_W'(1);
                    end
                end
                default: begin
                    state_r <= TMR_IDLE;
                end
            endcase
        end
    end

    // Result is taken only when a timer runs out
    always_ff @(posedge clk) begin
        if (srst || !diag_en) begin
            sample_p    <= 1'b0;
            sample_code <= `CODE_NONE;
            det_code    <= `CODE_NONE;
        end else begin
            sample_p <= expire && !(restart_all || cmd_on != cmd_d_r)
                        && !(state_r == TMR_FILTER && raw != raw_d_r);
            if (expire) begin
                sample_code <= raw;
                det_code    <= raw;
            end
        end
    end
endmodule : chan_diag

//--- src/channel_fault_capture_flags.sv
`timescale 1ns/10ps
`include "fault_map.svh"
module channel_fault_capture_flags #(
    parameter int NCH = `NUM_CH
) (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   master_enable_a,
    input  wire logic                   master_enable_b,
    input  wire logic                   frame_select_n,
    input  wire logic                   frame_valid,
    input  wire logic [NCH-1:0]         parallel_channel_cmd,
    input  wire logic [NCH-1:0]         serial_channel_cmd,
    input  wire logic [NCH-1:0]         channel_mask,
    input  wire logic [NCH-1:0]         drain_above_open_ref,
    input  wire logic [NCH-1:0]         drain_below_gnd_ref,
    input  wire logic [NCH-1:0]         drain_above_short_ref,
    input  wire logic                   drain_status_flag_n_i,
    output logic                        drain_status_flag_n_o,
    output logic                        drain_status_flag_n_oe_n,
    input  wire logic                   fault_flag_n_i,
    output logic                        fault_flag_n_o,
    output logic                        fault_flag_n_oe_n,
    output logic                        bias_enable,
    output logic                        offstate_diag_en,
    output logic [`FRAME_BITS-1:0]      shift_load_data,
    output logic                        shift_load,
    output logic                        reg_write_allow,
    output logic                        status_line_low,
    output logic                        fault_line_low
);
    import fault_types_pkg::*;

    // ****************************************************
    // Synchronisers
    // ****************************************************
    logic           ena_a;
    logic           ena_b;
    logic           sel;
    logic [NCH-1:0] above_ol;
    logic [NCH-1:0] below_sg;
    logic [NCH-1:0] above_short;
    logic           stat_line;
    logic           flt_line;

    sync_2ff #(
        .W (1)
    ) u_sync_ena_a (
        .clk  (clk),
        .srst (srst),
        .d    (master_enable_a),
        .q    (ena_a)
    );

    sync_2ff #(
        .W (1)
    ) u_sync_ena_b (
        .clk  (clk),
        .srst (srst),
        .d    (master_enable_b),
        .q    (ena_b)
    );

    // Select is inverted so that an idle line reads as zero
    sync_2ff #(
        .W (1)
    ) u_sync_sel (
        .clk  (clk),
        .srst (srst),
        .d    (~frame_select_n),
        .q    (sel)
    );

    sync_2ff #(
        .W (NCH)
    ) u_sync_open (
        .clk  (clk),
        .srst (srst),
        .d    (drain_above_open_ref),
        .q    (above_ol)
    );

    sync_2ff #(
        .W (NCH)
    ) u_sync_gnd (
        .clk  (clk),
        .srst (srst),
        .d    (drain_below_gnd_ref),
        .q    (below_sg)
    );

    sync_2ff #(
        .W (NCH)
    ) u_sync_short (
        .clk  (clk),
        .srst (srst),
        .d    (drain_above_short_ref),
        .q    (above_short)
    );

    sync_2ff #(
        .W (1)
    ) u_sync_stat (
        .clk  (clk),
        .srst (srst),
        .d    (~drain_status_flag_n_i),
        .q    (stat_line)
    );

    sync_2ff #(
        .W (1)
    ) u_sync_flt (
        .clk  (clk),
        .srst (srst),
        .d    (~fault_flag_n_i),
        .q    (flt_line)
    );

    // ****************************************************
    // Edge detection
    // ****************************************************
    logic both_d_r;
    logic sel_d_r;
    logic both_en;
    logic restart_all;
    logic sel_fall;
    logic sel_rise;

    always_ff @(posedge clk) begin
        if (srst) begin
            both_d_r <= 1'b0;
        end else begin
            both_d_r <= both_en;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sel_d_r <= 1'b0;
        end else begin
            sel_d_r <= sel;
        end
    end

    assign both_en     = ena_a && ena_b;
    assign restart_all = both_en && !both_d_r;
    assign sel_fall    = sel && !sel_d_r;
    assign sel_rise    = !sel && sel_d_r;

    // ****************************************************
    // Per-channel classification and timers
    // ****************************************************
    logic [NCH-1:0] cmd_on;
    logic [NCH-1:0] sample_p;
    fault_code_t    sample_code [NCH];
    fault_code_t    det_code    [NCH];

    assign cmd_on = parallel_channel_cmd | serial_channel_cmd;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        chan_diag u_chan (
            .clk         (clk),
            .srst        (srst),
            .diag_en     (both_en),
            .restart_all (restart_all),
            .cmd_on      (cmd_on[i]),
            .above_ol    (above_ol[i]),
            .below_sg    (below_sg[i]),
            .above_short (above_short[i]),
            .sample_p    (sample_p[i]),
            .sample_code (sample_code[i]),
            .det_code    (det_code[i])
        );
    end

    // ****************************************************
    // Fault latches
    // ****************************************************
    fault_code_t    latch_r [NCH];
    logic           rearm;
    logic [NCH-1:0] held;
    logic [NCH-1:0] capture;

    // Valid frame end re-arms; the current detection is recaptured at once
    assign rearm = sel_rise && frame_valid;

    // A held latch ignores new samples until the next valid frame end
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            held[i]    = latch_r[i] != `CODE_NONE;
            capture[i] = !held[i] && sample_p[i] && sample_code[i] != `CODE_NONE;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (srst || !ena_a) begin
                latch_r[i] <= `CODE_NONE;
            end else if (rearm) begin
                latch_r[i] <= det_code[i];
            end else if (capture[i]) begin
                latch_r[i] <= sample_code[i];
            end
        end
    end

    // ****************************************************
    // Serial frame interface
    // ****************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_load <= 1'b0;
        end else begin
            shift_load <= sel_fall;
        end
    end

    // Writes are allowed only after a valid frame end
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_write_allow <= 1'b0;
        end else begin
            reg_write_allow <= rearm;
        end
    end

    // Unused upper bits of the frame stay zero
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_load_data <= '0;
        end else if (sel_fall) begin
            for (int i = 0; i < NCH; i++) begin
                shift_load_data[2*i +: 2] <= latch_r[i];
            end
        end
    end

    // ****************************************************
    // Status and fault flags
    // ****************************************************
    logic [NCH-1:0] low_fb;
    logic [NCH-1:0] faulted;
    logic           stat_set;
    logic           flt_set;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            low_fb[i]  = !above_ol[i] && !channel_mask[i];
            faulted[i] = held[i] && !channel_mask[i];
        end
    end

    // Select line idle high on two samples, so the flag drops as a frame starts
    assign stat_set = ena_a && (|low_fb);
    assign flt_set  = both_en && !sel && !sel_d_r && (|faulted);

    // ****************************************************
    // Flag and enable outputs
    // ****************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            drain_status_flag_n_oe_n <= 1'b1;
        end else begin
            drain_status_flag_n_oe_n <= !stat_set;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_flag_n_oe_n <= 1'b1;
        end else begin
            fault_flag_n_oe_n <= !flt_set;
        end
    end

    // Bias currents run only with both enables high
    always_ff @(posedge clk) begin
        if (srst) begin
            bias_enable <= 1'b0;
        end else begin
            bias_enable <= both_en;
        end
    end

    // Off-state checks run only with both enables high
    always_ff @(posedge clk) begin
        if (srst) begin
            offstate_diag_en <= 1'b0;
        end else begin
            offstate_diag_en <= both_en;
        end
    end

    // Read-back of the shared open-drain lines
    always_ff @(posedge clk) begin
        if (srst) begin
            status_line_low <= 1'b0;
        end else begin
            status_line_low <= stat_line;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_line_low <= 1'b0;
        end else begin
            fault_line_low <= flt_line;
        end
    end

    // Open-drain pins only ever pull low
    assign drain_status_flag_n_o = 1'b0;
    assign fault_flag_n_o        = 1'b0;

endmodule : channel_fault_capture_flags

//--- src/fault_map.svh
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH

// Clock rate, channel count, frame width and counter width
`define CLK_MHZ        250
`define NUM_CH         6
`define FRAME_BITS     16
`define CNT_W          12

// Timer lengths in ns, rounded up to whole clock cycles
`define T_BL_ON_NS     2000
`define T_BL_OFF_NS    4000
`define T_FILT_NS      1000
`define CYC_BL_ON      ((`T_BL_ON_NS * `CLK_MHZ + 999) / 1000)
`define CYC_BL_OFF     ((`T_BL_OFF_NS * `CLK_MHZ + 999) / 1000)
`define CYC_FILT       ((`T_FILT_NS * `CLK_MHZ + 999) / 1000)

// Two-bit channel fault codes
`define CODE_NONE      2'h0
`define CODE_OPEN      2'h1
`define CODE_GND       2'h2
`define CODE_SHORT     2'h3

`endif

//--- src/fault_types_pkg.sv
package fault_types_pkg;

    typedef logic [1:0] fault_code_t;

    typedef enum logic [2:0] {
        TMR_IDLE   = 3'b001,
        TMR_BLANK  = 3'b010,
        TMR_FILTER = 3'b100
    } timer_state_t;

endpackage : fault_types_pkg

//--- src/sync_2ff.sv
`timescale 1ns/10ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : sync_2ff

//--- verif/flag_checker_assertions.sv
`timescale 1ns/10ps
`include "fault_map.svh"
// *****
// Flag and frame checks
// *****
module flag_checker #(
    parameter int NCH = `NUM_CH
) (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire logic                   master_enable_a,
    input wire logic                   master_enable_b,
    input wire logic                   frame_select_n,
    input wire logic                   frame_valid,
    input wire logic [NCH-1:0]         channel_mask,
    input wire logic [NCH-1:0]         drain_above_open_ref,
    input logic                        drain_status_flag_n_oe_n,
    input logic                        fault_flag_n_oe_n,
    input logic                        bias_enable,
    input logic                        offstate_diag_en,
    input logic [`FRAME_BITS-1:0]      shift_load_data,
    input logic                        shift_load,
    input logic                        reg_write_allow
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    stat_off_a: assert property (!master_enable_a [*5] |-> drain_status_flag_n_oe_n)
        else $error("status flag held with first enable low");
    stat_mask_a: assert property (&channel_mask [*3] |-> drain_status_flag_n_oe_n)
        else $error("status flag held with all channels masked");
    stat_set_a: assert property ((master_enable_a && |(~channel_mask & ~drain_above_open_ref))
        [*5] |-> !drain_status_flag_n_oe_n)
        else $error("status flag not pulled low");
    stat_clr_a: assert property ((master_enable_a && &(channel_mask | drain_above_open_ref))
        [*5] |-> drain_status_flag_n_oe_n)
        else $error("status flag not released");
    flt_sel_a: assert property (!frame_select_n [*4] |-> fault_flag_n_oe_n)
        else $error("fault flag held while select low");
    ena_low_a: assert property ((!master_enable_a || !master_enable_b) [*5] |->
        fault_flag_n_oe_n && !bias_enable && !offstate_diag_en)
        else $error("outputs active with an enable low");
    bias_on_a: assert property ((master_enable_a && master_enable_b) [*5] |->
        bias_enable && offstate_diag_en)
        else $error("bias off with both enables high");
    load_fall_a: assert property ($fell(frame_select_n) |-> ##[2:4] shift_load)
        else $error("no shift load after select fall");
    load_pad_a: assert property (shift_load |-> shift_load_data[15:12] == 4'h0 ##1 !shift_load)
        else $error("shift load malformed");
    wr_block_a: assert property (!frame_valid [*6] |-> !reg_write_allow)
        else $error("write allowed after invalid frame");
    rst_state_a: assert property (disable iff (1'b0) srst |=> fault_flag_n_oe_n &&
        drain_status_flag_n_oe_n && !shift_load)
        else $error("flags not released in reset");
    cover property (shift_load);
    cover property (reg_write_allow);
    cover property (!fault_flag_n_oe_n);
endmodule : flag_checker

bind channel_fault_capture_flags flag_checker #(.NCH(NCH)) chk (
    .clk(clk), .srst(srst), .master_enable_a(master_enable_a),
    .master_enable_b(master_enable_b), .frame_select_n(frame_select_n),
    .frame_valid(frame_valid), .channel_mask(channel_mask),
    .drain_above_open_ref(drain_above_open_ref),
    .drain_status_flag_n_oe_n(drain_status_flag_n_oe_n),
    .fault_flag_n_oe_n(fault_flag_n_oe_n), .bias_enable(bias_enable),
    .offstate_diag_en(offstate_diag_en), .shift_load_data(shift_load_data),
    .shift_load(shift_load), .reg_write_allow(reg_write_allow));

//--- verif/host_model.sv
`timescale 1ns/10ps
// *****
// Host side of flag lines and frame select
// *****
module host_model (
    input  wire logic        clk,
    input  wire logic        stat_o,
    input  wire logic        stat_oe_n,
    input  wire logic        flt_o,
    input  wire logic        flt_oe_n,
    input  wire logic        shift_load,
    input  wire logic [15:0] shift_load_data,
    output logic             stat_pin,
    output logic             flt_pin,
    output logic             frame_select_n,
    output logic             frame_valid
);
    // Pull-ups hold released lines high
    assign stat_pin = stat_oe_n ? 1'b1 : stat_o;
    assign flt_pin  = flt_oe_n ? 1'b1 : flt_o;
    initial begin
        frame_select_n = 1'b1;
        frame_valid    = 1'b1;
    end
    // One frame is 16 link clock periods of 32 ns
    task automatic frame(input logic v, output logic [15:0] d, output logic seen);
        seen = 1'b0;
        d = 16'h0;
        @(posedge clk);
        frame_select_n <= 1'b0;
        frame_valid    <= v;
        repeat (128) begin
            @(posedge clk);
            #1;
            if (shift_load === 1'b1) begin
                seen = 1'b1;
                d = shift_load_data;
            end
        end
        frame_select_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : frame
endmodule : host_model

//--- verif/tb_top.sv
`timescale 1ns/10ps
// *****
// Scenario bench for fault capture and flags
// *****
module tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ena_a = 1'b0;
    logic        ena_b = 1'b0;
    logic [5:0]  pcmd = 6'h0, scmd = 6'h0, mask = 6'h0;
    logic [5:0]  above_ol = 6'h3f, below_sg = 6'h0, above_sh = 6'h0;
    logic        stat_o, stat_oe_n, flt_o, flt_oe_n, bias_en, diag_en;
    logic        sl, wr_ok, st_low, fl_low, stat_pin, flt_pin, sel_n, fvalid;
    logic [15:0] sl_data;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_wr = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (wr_ok === 1'b1) n_wr <= n_wr + 1;

    channel_fault_capture_flags dut (
        .clk(clk), .srst(srst), .master_enable_a(ena_a), .master_enable_b(ena_b),
        .frame_select_n(sel_n), .frame_valid(fvalid), .parallel_channel_cmd(pcmd),
        .serial_channel_cmd(scmd), .channel_mask(mask), .drain_above_open_ref(above_ol),
        .drain_below_gnd_ref(below_sg), .drain_above_short_ref(above_sh),
        .drain_status_flag_n_i(stat_pin), .drain_status_flag_n_o(stat_o),
        .drain_status_flag_n_oe_n(stat_oe_n), .fault_flag_n_i(flt_pin),
        .fault_flag_n_o(flt_o), .fault_flag_n_oe_n(flt_oe_n), .bias_enable(bias_en),
        .offstate_diag_en(diag_en), .shift_load_data(sl_data), .shift_load(sl),
        .reg_write_allow(wr_ok), .status_line_low(st_low), .fault_line_low(fl_low));

    host_model host (
        .clk(clk), .stat_o(stat_o), .stat_oe_n(stat_oe_n), .flt_o(flt_o),
        .flt_oe_n(flt_oe_n), .shift_load(sl), .shift_load_data(sl_data),
        .stat_pin(stat_pin), .flt_pin(flt_pin), .frame_select_n(sel_n),
        .frame_valid(fvalid));

    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wait_flt(input logic want, input int lim, input string m);
        for (int i = 0; i < lim && flt_pin !== want; i++) cyc(1);
        chk(16'(flt_pin), 16'(want), m);
        if (flt_pin !== want) close_out();
    endtask : wait_flt

    task automatic rd(input logic v, input logic [15:0] exp, input string m);
        logic [15:0] d;
        logic        seen;
        int          w0;
        w0 = n_wr;
        host.frame(v, d, seen);
        chk(16'(seen), 16'h1, m);
        chk(d, exp, m);
        chk(16'(n_wr - w0), 16'(v), "write pulse count");
    endtask : rd

    task automatic t_status();
        @(posedge clk) ena_a <= 1'b1;
        above_ol[0] <= 1'b0;
        cyc(6);
        chk(16'(stat_pin), 16'h0, "status not set");
        chk(16'(bias_en), 16'h0, "bias on with one enable");
        @(posedge clk) mask <= 6'h3f;
        cyc(4);
        chk(16'(stat_pin), 16'h1, "status not masked");
        @(posedge clk) mask <= 6'h0;
        above_ol <= 6'h3b;
        cyc(6);
        chk(16'(stat_pin), 16'h0, "status other channel");
        chk(16'(st_low), 16'h1, "status line readback");
        chk(16'(flt_pin), 16'h1, "fault with second enable low");
    endtask : t_status

    task automatic t_open();
        @(posedge clk) ena_b <= 1'b1;
        wait_flt(1'b0, 1100, "open load not flagged");
        cyc(4);
        chk(16'(fl_low), 16'h1, "fault line readback");
        rd(1'b1, 16'h0010, "open load code");
        wait_flt(1'b0, 10, "fault not raised again");
    endtask : t_open

    task automatic t_hold();
        @(posedge clk) below_sg[2] <= 1'b1;
        cyc(300);
        rd(1'b0, 16'h0010, "held code after invalid");
        rd(1'b1, 16'h0010, "held code before rearm");
        rd(1'b1, 16'h0020, "ground short after rearm");
    endtask : t_hold

    task automatic t_short();
        @(posedge clk) pcmd[0] <= 1'b1;
        scmd[1] <= 1'b1;
        above_sh[0] <= 1'b1;
        above_ol[1] <= 1'b0;
        cyc(600);
        rd(1'b1, 16'h0023, "shorted load code");
    endtask : t_short

    task automatic t_recover();
        @(posedge clk) above_sh <= 6'h0;
        above_ol <= 6'h3f;
        below_sg <= 6'h0;
        cyc(20);
        @(posedge clk) ena_a <= 1'b0;
        cyc(10);
        chk(16'(flt_pin), 16'h1, "fault with first enable low");
        chk(16'(diag_en), 16'h0, "diagnostics on");
        chk(16'(fl_low), 16'h0, "fault line still low");
        @(posedge clk) ena_a <= 1'b1;
        cyc(1200);
        chk(16'(flt_pin), 16'h1, "fault after recovery");
        rd(1'b1, 16'h0000, "latches not cleared");
    endtask : t_recover

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        cyc(2);
        chk({stat_pin, flt_pin, sl_data[13:0]}, 16'hc000, "reset state");
        t_status();
        t_open();
        t_hold();
        t_short();
        t_recover();
        close_out();
    end
endmodule : tb_top
